// file: design/nmd_ctrl.sv
// Controller that drives a 1M x 1 nibble-mode DRAM through its pins.
// Assumes a 10 MHz clock; one request at a time from the user side.
`timescale 1ns/1ns
`default_nettype none
module nmd_ctrl
   import nmd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_nibble,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [NIBBLE_BITS-1:0] req_wdata,
   input wire logic dram_dout,
   output logic req_ready,
   output logic rsp_valid,
   output logic [NIBBLE_BITS-1:0] rsp_rdata,
   output logic init_done,
   output logic [MUX_W-1:0] muxed_address,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic dram_din
);
   typedef enum logic [7:0] {
      S_PWR = 8'h01, S_IDLE = 8'h02, S_ROW = 8'h04, S_COL = 8'h08,
      S_CASL = 8'h10, S_CASH = 8'h20, S_RPRE = 8'h40, S_REF = 8'h80
   } nmd_state_t;
   nmd_state_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, ref_q, ref_d, low_q, low_d;
   logic [3:0] init_q, init_d;
   logic [1:0] nib_q, nib_d;
   logic wr_q, wr_d, nb_q, nb_d, refp_q, refp_d, rfc_q, rfc_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [NIBBLE_BITS-1:0] wd_q, wd_d, rd_q, rd_d;
   logic ras_d, cas_d, we_d, din_d, rdy_d, rv_d, done_d;
   logic [NIBBLE_BITS-1:0] rdat_d;
   logic [MUX_W-1:0] ma_d;
   logic dout_s;
   nmd_sync u_sync (.clock(clock), .rst(rst), .din(dram_dout), .dout(dout_s));
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      init_d = init_q;
      nib_d = nib_q;
      wr_d = wr_q;
      nb_d = nb_q;
      addr_d = addr_q;
      wd_d = wd_q;
      rd_d = rd_q;
      ras_d = ras_n;
      cas_d = cas_n;
      we_d = we_n;
      din_d = dram_din;
      ma_d = muxed_address;
      rdy_d = 1'b0;
      rv_d = 1'b0;
      done_d = init_done;
      rdat_d = rsp_rdata;
      rfc_d = rfc_q;
      // Refresh pacing
      ref_d = (ref_q == CNT_W'(REF_INT_CYC - 1)) ? '0 : ref_q + 1'b1;
      refp_d = refp_q | (ref_q == CNT_W'(REF_INT_CYC - 1));
      low_d = ras_n ? '0 : low_q + 1'b1;
      case (st_q)
         S_PWR: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(PWRUP_CYC - 1)) begin
               st_d = S_RPRE;
               cnt_d = '0;
               rfc_d = 1'b0;
            end
         end
         S_IDLE: begin
            rdy_d = ~refp_d & init_q == 4'(INIT_CYCLES);
            if (init_q != 4'(INIT_CYCLES) || refp_q) begin
               // Column-before-row refresh; init cycles use it too
               cas_d = 1'b0;
               st_d = S_REF;
               rfc_d = 1'b1;
               // A pacing tick in this same cycle must not be lost
               refp_d = (ref_q == CNT_W'(REF_INT_CYC - 1));
               if (init_q != 4'(INIT_CYCLES)) init_d = init_q + 1'b1;
            end else if (req_valid && req_ready) begin
               wr_d = req_write;
               nb_d = req_nibble;
               addr_d = req_addr;
               wd_d = req_wdata;
               nib_d = RESET_NIB;
               rdy_d = 1'b0;
               rfc_d = 1'b0;
               ma_d = req_addr[ADDR_W-1:MUX_W];
               st_d = S_ROW;
            end
         end
         S_ROW: begin
            ras_d = 1'b0;
            st_d = S_COL;
         end
         S_COL: begin
            ma_d = addr_q[MUX_W-1:0];
            we_d = ~wr_q;
            din_d = wd_q[0];
            st_d = S_CASL;
         end
         S_CASL: begin
            cas_d = 1'b0;
            cnt_d = '0;
            st_d = S_CASH;
         end
         S_CASH: begin
            // Column strobe stays low until the read bit is through the synchroniser
            if (cnt_q != CNT_W'(CAS_WAIT_CYC)) begin
               cnt_d = cnt_q + 1'b1;
            end else begin
               cnt_d = '0;
               if (!wr_q) rd_d[nib_q] = dout_s;
               cas_d = 1'b1;
               if (nb_q && nib_q != 2'(NIBBLE_BITS - 1)
                   && low_q < CNT_W'(ROW_LOW_MAX_BURST_CYC - 4)) begin
                  nib_d = nib_q + 1'b1;
                  din_d = wd_q[nib_q + 1'b1];
                  st_d = S_CASL;
               end else begin
                  ras_d = 1'b1;
                  st_d = S_RPRE;
                  rv_d = 1'b1;
                  rdat_d = rd_d;
               end
            end
         end
         S_REF: begin
            if (!ras_n) begin
               ras_d = 1'b1;
               cas_d = 1'b1;
               st_d = S_RPRE;
            end else begin
               ras_d = 1'b0;
            end
         end
         S_RPRE: begin
            we_d = 1'b1;
            if (init_q == 4'(INIT_CYCLES)) done_d = 1'b1;
            st_d = S_IDLE;
         end
         default: st_d = S_PWR;
      endcase
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= S_PWR;
         cnt_q <= '0;
         ref_q <= '0;
         low_q <= '0;
         init_q <= '0;
         nib_q <= RESET_NIB;
         wr_q <= 1'b0;
         nb_q <= 1'b0;
         refp_q <= 1'b0;
         rfc_q <= 1'b0;
         addr_q <= '0;
         wd_q <= '0;
         rd_q <= '0;
         ras_n <= 1'b1;
         cas_n <= 1'b1;
         we_n <= 1'b1;
         dram_din <= 1'b0;
         muxed_address <= '0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         init_done <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ref_q <= ref_d;
         low_q <= low_d;
         init_q <= init_d;
         nib_q <= nib_d;
         wr_q <= wr_d;
         nb_q <= nb_d;
         refp_q <= refp_d;
         rfc_q <= rfc_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         ras_n <= ras_d;
         cas_n <= cas_d;
         we_n <= we_d;
         dram_din <= din_d;
         muxed_address <= ma_d;
         req_ready <= rdy_d;
         rsp_valid <= rv_d;
         init_done <= done_d;
         rsp_rdata <= rdat_d;
      end
   end
   // Checks
   property p_pwr_wait;
      @(posedge clock) disable iff (rst) (st_q == S_PWR) |-> ras_n && cas_n;
   endproperty
   a_pwr_wait: assert property (p_pwr_wait) else $error("strobe during power wait");
   property p_cbr;
      @(posedge clock) disable iff (rst) $fell(ras_n) |-> (!cas_n == rfc_q);
   endproperty
   a_cbr: assert property (p_cbr) else $error("refresh without early cas");
   property p_burst_len;
      @(posedge clock) disable iff (rst) !ras_n |-> low_q < CNT_W'(ROW_LOW_MAX_BURST_CYC);
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("row strobe low too long");
   property p_we_stable;
      @(posedge clock) disable iff (rst) !cas_n && st_q != S_REF |-> $stable(we_n);
   endproperty
   a_we_stable: assert property (p_we_stable) else $error("we moved under cas");
   property p_rd_we;
      @(posedge clock) disable iff (rst) !cas_n && !wr_q && st_q == S_CASH |-> we_n;
   endproperty
   a_rd_we: assert property (p_rd_we) else $error("read with we low");
   property p_pre;
      @(posedge clock) disable iff (rst) $rose(ras_n) |-> ##1 ras_n;
   endproperty
   a_pre: assert property (p_pre) else $error("no precharge");
   property p_nib;
      @(posedge clock) disable iff (rst) st_q == S_CASH |-> nib_q <= 2'(NIBBLE_BITS - 1);
   endproperty
   a_nib: assert property (p_nib) else $error("nibble overrun");
   property p_row_first;
      @(posedge clock) disable iff (rst) st_q == S_ROW |=> !ras_n && cas_n;
   endproperty
   a_row_first: assert property (p_row_first) else $error("row not first");
   c_ref: cover property (@(posedge clock) disable iff (rst) st_q == S_REF);
   c_wr: cover property (@(posedge clock) disable iff (rst) rsp_valid && wr_q);
   c_nib: cover property (@(posedge clock) disable iff (rst) st_q == S_CASH && nib_q == 2'h3);
endmodule
`default_nettype wire

// file: design/nmd_pkg.sv
// Constants for the nibble-mode DRAM controller.
// Assumes a 10 MHz system clock.
package nmd_pkg;
   localparam int CLK_NS = 100;
   localparam int PWRUP_US = 100;
   localparam int PWRUP_CYC = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int INIT_CYCLES = 8;
   localparam int REFRESH_ROWS = 512;
   localparam int REFRESH_MS = 8;
   localparam int REF_INT_CYC = (REFRESH_MS * 1000000 / CLK_NS) / REFRESH_ROWS;
   localparam int ROW_LOW_MAX_NS = 10000;
   localparam int ROW_LOW_MAX_BURST_NS = 100000;
   localparam int ROW_LOW_MAX_CYC = ROW_LOW_MAX_NS / CLK_NS;
   localparam int ROW_LOW_MAX_BURST_CYC = ROW_LOW_MAX_BURST_NS / CLK_NS;
   localparam int NIBBLE_BITS = 4;
   localparam int CAS_WAIT_CYC = 2;
   localparam int ADDR_W = 20;
   localparam int MUX_W = 10;
   localparam int CNT_W = 16;
   localparam logic [1:0] RESET_NIB = 2'h0;
endpackage

// file: design/nmd_sync.sv
// Two-flop synchroniser for one level.
// Assumes a single clock domain at the destination.
`timescale 1ns/1ns
`default_nettype none
module nmd_sync (
   input wire logic clock,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   logic meta_d;
   logic out_d;
   always_comb begin
      meta_d = din;
      out_d = meta_q;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= meta_d;
         dout <= out_d;
      end
   end
endmodule
`default_nettype wire

// file: sim/nmd_dram_model.sv
// Behavioural 1M x 1 nibble-mode dynamic RAM.
// Assumes the controller drives all strobes; released output shows inverted data.
`timescale 1ns/1ns
`default_nettype none
module nmd_dram_model (
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [9:0] muxed_address,
   input wire logic dram_din,
   output logic dram_dout
);
   logic mem [0:1048575];
   logic [9:0] row, col;
   logic [19:0] a;
   logic [1:0] nib, k;
   logic first = 1'b0;
   initial dram_dout = 1'b0;
   // Row latch; refresh needs no address
   always @(negedge ras_n) begin
      row = muxed_address;
      first = 1'b1;
   end
   always @(negedge cas_n) begin
      if (!ras_n) begin
         if (first) begin
            col = muxed_address;
            nib = 2'h0;
         end else begin
            nib = nib + 2'h1;
         end
         first = 1'b0;
         k = {row[9], col[9]} + nib;
         a = {k[1], row[8:0], k[0], col[8:0]};
         if (!we_n) mem[a] = dram_din;
         else dram_dout = mem[a];
      end
   end
   always @(posedge cas_n) dram_dout = ~dram_dout;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the nibble-mode DRAM controller.
// Assumes the behavioural DRAM model on the far side.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import nmd_pkg::*;
   logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_nibble = 1'b0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [NIBBLE_BITS-1:0] req_wdata = '0, rsp_rdata;
   logic req_ready, rsp_valid, init_done, ras_n, cas_n, we_n, dram_din, dram_dout, last_we;
   logic [MUX_W-1:0] muxed_address;
   int fails = 0, n_compared = 0, n_cbr = 0, low = 0;
   time t_rel = 0, t_ras = 0;
   always #50 clock = ~clock;
   nmd_ctrl dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_write(req_write),
      .req_nibble(req_nibble), .req_addr(req_addr), .req_wdata(req_wdata),
      .dram_dout(dram_dout), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .init_done(init_done), .muxed_address(muxed_address),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dram_din(dram_din));
   nmd_dram_model mem_i (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .muxed_address(muxed_address), .dram_din(dram_din), .dram_dout(dram_dout));
   always @(posedge clock) begin
      low <= ras_n ? 0 : low + 1;
      if (low > ROW_LOW_MAX_BURST_CYC) chk("row low time", 0, 1);
   end
   always @(negedge ras_n) begin
      if (t_ras == 0) t_ras = $time;
      if (!cas_n) n_cbr++;
   end
   always @(negedge cas_n) if (!ras_n) last_we = we_n;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic access(input logic w, input logic nb, input logic [ADDR_W-1:0] a,
      input logic [NIBBLE_BITS-1:0] d, output logic [NIBBLE_BITS-1:0] r);
      int i;
      req_write <= w;
      req_nibble <= nb;
      req_addr <= a;
      req_wdata <= d;
      req_valid <= 1'b1;
      for (i = 0; i < 400; i++) begin
         #1;
         if (req_ready === 1'b1) break;
         @(posedge clock);
      end
      if (i == 400) begin
         fails++;
         results();
      end
      @(posedge clock);
      req_valid <= 1'b0;
      for (i = 0; i < 60 && i < 400; i++) begin
         @(posedge clock);
         #1;
         if (rsp_valid === 1'b1) break;
      end
      if (i >= 60) begin
         fails++;
         results();
      end
      r = rsp_rdata;
      @(posedge clock);
   endtask
   task automatic t_init();
      int i;
      for (i = 0; i < 3000 && init_done !== 1'b1; i++) @(posedge clock);
      if (i == 3000) begin
         fails++;
         results();
      end
      chk("power wait", 1, t_ras - t_rel >= PWRUP_US * 1000);
      chk("init row cycles", 1, n_cbr >= INIT_CYCLES);
   endtask
   task automatic t_single(input logic v);
      logic [3:0] r;
      access(1'b1, 1'b0, 20'h2A5C3, {3'h0, v}, r);
      chk("write we_n", 0, last_we);
      access(1'b0, 1'b0, 20'h2A5C3, 4'h0, r);
      chk("read we_n", 1, last_we);
      chk("single read", v, r[0]);
   endtask
   task automatic t_nibble();
      logic [3:0] r;
      access(1'b1, 1'b1, 20'h8A7B3, 4'h6, r);
      access(1'b0, 1'b1, 20'h8A7B3, 4'h0, r);
      chk("nibble read", 4'h6, r);
      access(1'b0, 1'b0, 20'h0A5B3, 4'h0, r);
      chk("wrap bit1", 1, r[0]);
      access(1'b0, 1'b0, 20'h8A5B3, 4'h0, r);
      chk("wrap bit3", 0, r[0]);
   endtask
   task automatic t_refresh();
      int c;
      c = n_cbr;
      repeat (2 * REF_INT_CYC + 10) @(posedge clock);
      chk("refresh count", 1, n_cbr - c >= 2);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      t_rel = $time;
      t_init();
      t_single(1'b1);
      t_single(1'b0);
      t_nibble();
      t_refresh();
      t_single(1'b1);
      results();
   end
endmodule
`default_nettype wire
